// [adc_out_pkg.sv]
//==============================================================================
// Behaviour
// - Latch clock mode when power-on reset ends.
// - Pull clock pin up; low selects external.
// - Clock and data high while converting.
// - Conversion done drives clock, data low.
// - Continuous: sleep half period, then output.
// - Transfer spans first through 24th rising edge.
// - Data changes on falling edges; clock driven.
// - Bits stay valid across sampling rising edges.
// - After 24th edge data high, clock high.
// - Autostart: weak pull-up holds chip select high.
// - Autostart: sleep discharges chip select capacitor.
// - Threshold crossing starts output automatically.
// - Autostart: after 24th edge, chip select high.
// - Each threshold crossing re-selects internal clock.
package adc_out_pkg;

    localparam int CLK_FREQ_HZ = 125000000;
    localparam int POR_TIME_NS = 500000;
    localparam int POR_CYCLES = (POR_TIME_NS / 1000) * (CLK_FREQ_HZ / 1000000);
    localparam int RESULT_BITS = 24;
    localparam int HALF_DIV_DEFAULT = 8;
    localparam int SLEEP_CYCLES_DEFAULT = 64;
    localparam int CONV_CYCLES_DEFAULT = 200;
    localparam int FIFO_DEPTH_DEFAULT = 16;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_CONVERT = 3'b001,
        ST_SLEEP = 3'b010,
        ST_SHIFT_HIGH = 3'b011,
        ST_SHIFT_LOW = 3'b100,
        ST_EXT_IDLE = 3'b101
    } state_type;

endpackage

// [result_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Result buffer between the conversion source and the shifter.
module result_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_o = (count_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage is written only, so it needs no reset.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // result_fifo
`default_nettype wire

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Three-stage synchroniser; the level moves once stages two and three agree.
module pin_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] sync_q;

    // Stage one feeds only stage two, so metastability stays contained.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_q <= {3{INIT}};
            level_o <= INIT;
        end else begin
            sync_q <= {sync_q[1:0], pin_i};
            if (sync_q[1] == sync_q[2]) begin
                level_o <= sync_q[2];
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// [adc_serial_out.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Self-clocked result output of a delta-sigma converter.
// Continuous mode: chip select tied low. Autostart: chip select carries a
// timing capacitor, modelled as a sleep countdown that then pulls the pin low.
module adc_serial_out #(
    parameter int HALF_DIV = adc_out_pkg::HALF_DIV_DEFAULT,
    parameter int SLEEP_CYCLES = adc_out_pkg::SLEEP_CYCLES_DEFAULT,
    parameter int CONV_CYCLES = adc_out_pkg::CONV_CYCLES_DEFAULT,
    parameter int POR_CYCLES = adc_out_pkg::POR_CYCLES,
    parameter int FIFO_DEPTH = adc_out_pkg::FIFO_DEPTH_DEFAULT
) (
    // Clock and power-on reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Result stream from the conversion core.
    input wire logic result_valid_i,
    output logic result_ready_o,
    input wire logic [adc_out_pkg::RESULT_BITS-1:0] result_data_i,
    // Serial clock pin.
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic sclk_pullup_o,
    // Serial data pin.
    output logic sdo_o,
    // Chip select pin, an input with a weak pull-up and a current sink.
    input wire logic cs_n_i,
    output logic cs_pullup_o,
    output logic cs_sink_o,
    // Status.
    output logic ext_mode_o,
    output logic converting_o,
    // Rate select pin for the notch filter, passed to the core.
    input wire logic notch_frequency_select_i,
    output logic notch_frequency_select_o
);
    localparam int RB = adc_out_pkg::RESULT_BITS;
    localparam int BW = $clog2(RB + 1);
    localparam int DW = $clog2(HALF_DIV + 1);
    localparam int TW = $clog2(POR_CYCLES + SLEEP_CYCLES + CONV_CYCLES + 1);

    adc_out_pkg::state_type state_q;
    logic [TW-1:0] timer_q;
    logic [DW-1:0] div_q;
    logic [BW-1:0] bit_q;
    logic [RB-1:0] shreg_q;
    logic sclk_lvl;
    logic cs_lvl;
    logic notch_lvl;
    logic fifo_valid;
    logic fifo_pop;
    logic [RB-1:0] fifo_data;
    logic half_tick;
    logic cs_prev_q;

    // =========================================================================
    // Input capture.
    pin_sync #(.INIT(1'b1)) sclk_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(sclk_i),
        .level_o(sclk_lvl)
    );

    pin_sync #(.INIT(1'b1)) cs_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(cs_n_i),
        .level_o(cs_lvl)
    );

    pin_sync #(.INIT(1'b0)) notch_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(notch_frequency_select_i),
        .level_o(notch_lvl)
    );

    // Results queue here so a slow drain stalls the conversion core.
    result_fifo #(
        .WIDTH(RB),
        .DEPTH(FIFO_DEPTH)
    ) result_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(result_valid_i),
        .in_ready_o(result_ready_o),
        .in_data_i(result_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // =========================================================================
    // Serial clock divider; each tick is one half period, fifty percent duty.
    assign half_tick = (div_q == DW'(HALF_DIV - 1));

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (state_q == adc_out_pkg::ST_SLEEP || state_q == adc_out_pkg::ST_SHIFT_HIGH
                     || state_q == adc_out_pkg::ST_SHIFT_LOW) begin
            div_q <= half_tick ? '0 : div_q + DW'(1);
        end else begin
            div_q <= '0;
        end
    end

    // A conversion ends once its time is up and a result is waiting.
    assign fifo_pop = (state_q == adc_out_pkg::ST_CONVERT) && (timer_q == '0) && fifo_valid;

    // =========================================================================
    // Sequencer: reset, convert, sleep, then shifting over 24 rising edges.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= adc_out_pkg::ST_RESET;
            timer_q <= TW'(POR_CYCLES);
            bit_q <= '0;
            shreg_q <= '0;
        end else begin
            unique case (state_q)
                adc_out_pkg::ST_RESET: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - TW'(1);
                    end else if (sclk_lvl) begin
                        state_q <= adc_out_pkg::ST_CONVERT;
                        timer_q <= TW'(CONV_CYCLES);
                    end else begin
                        state_q <= adc_out_pkg::ST_EXT_IDLE;
                    end
                end
                adc_out_pkg::ST_CONVERT: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - TW'(1);
                    end else if (fifo_pop) begin
                        state_q <= adc_out_pkg::ST_SLEEP;
                        shreg_q <= fifo_data;
                        timer_q <= TW'(SLEEP_CYCLES);
                    end
                end
                adc_out_pkg::ST_SLEEP: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - TW'(1);
                    end
                    // Continuous mode leaves after half a clock period; autostart
                    // waits for chip select to cross low or for the sleep timer to run out;
                    // the clock pin level is not read, so the internal clock is kept.
                    // The pin is driven low here, so its level says nothing about
                    // an outside driver; the mode stays internal.
                    if (half_tick && (!cs_lvl || timer_q == '0)) begin
                        state_q <= adc_out_pkg::ST_SHIFT_HIGH;
                        bit_q <= '0;
                    end
                end
                adc_out_pkg::ST_SHIFT_HIGH: begin
                    if (half_tick) begin
                        // The high phase with index RB-1 is the last rising edge.
                        if (bit_q == BW'(RB - 1)) begin
                            state_q <= adc_out_pkg::ST_CONVERT;
                            timer_q <= TW'(CONV_CYCLES);
                        end else begin
                            state_q <= adc_out_pkg::ST_SHIFT_LOW;
                        end
                    end
                end
                adc_out_pkg::ST_SHIFT_LOW: begin
                    if (half_tick) begin
                        state_q <= adc_out_pkg::ST_SHIFT_HIGH;
                        bit_q <= bit_q + BW'(1);
                        if (bit_q != '0) begin
                            shreg_q <= {shreg_q[RB-2:0], 1'b0};
                        end
                    end
                end
                adc_out_pkg::ST_EXT_IDLE: begin
                    // Externally clocked timing is outside this block.
                    state_q <= adc_out_pkg::ST_EXT_IDLE;
                end
                default: begin
                    state_q <= adc_out_pkg::ST_RESET;
                end
            endcase
        end
    end

    // =========================================================================
    // Pin drive. The first shift-high phase carries the done bit (low); later
    // phases carry result bits, most significant first.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_o <= 1'b1;
            sclk_oe_o <= 1'b0;
            sclk_pullup_o <= 1'b1;
            sdo_o <= 1'b1;
            cs_pullup_o <= 1'b0;
            cs_sink_o <= 1'b0;
            converting_o <= 1'b0;
            ext_mode_o <= 1'b0;
            notch_frequency_select_o <= 1'b0;
        end else begin
            notch_frequency_select_o <= notch_lvl;
            ext_mode_o <= (state_q == adc_out_pkg::ST_EXT_IDLE);
            converting_o <= (state_q == adc_out_pkg::ST_CONVERT);
            sclk_pullup_o <= (state_q == adc_out_pkg::ST_RESET)
                             || (state_q == adc_out_pkg::ST_SLEEP);
            cs_pullup_o <= (state_q == adc_out_pkg::ST_CONVERT);
            cs_sink_o <= (state_q == adc_out_pkg::ST_SLEEP);
            unique case (state_q)
                adc_out_pkg::ST_CONVERT: begin
                    sclk_oe_o <= 1'b1;
                    sclk_o <= 1'b1;
                    sdo_o <= 1'b1;
                end
                adc_out_pkg::ST_SLEEP: begin
                    sclk_oe_o <= 1'b1;
                    sclk_o <= 1'b0;
                    sdo_o <= 1'b0;
                end
                adc_out_pkg::ST_SHIFT_HIGH: begin
                    sclk_oe_o <= 1'b1;
                    sclk_o <= 1'b1;
                    sdo_o <= (bit_q == '0) ? 1'b0 : shreg_q[RB-1];
                end
                adc_out_pkg::ST_SHIFT_LOW: begin
                    sclk_oe_o <= 1'b1;
                    sclk_o <= 1'b0;
                    sdo_o <= (bit_q == '0) ? shreg_q[RB-1] : shreg_q[RB-2];
                end
                default: begin
                    sclk_oe_o <= 1'b0;
                    sclk_o <= 1'b1;
                    sdo_o <= 1'b1;
                end
            endcase
        end
    end

    // Previous chip select level, kept for visibility of the crossing.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_lvl;
        end
    end
endmodule // adc_serial_out
`default_nettype wire

// [adc_serial_out_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Port checker for the self-clocked result output.
module adc_serial_out_checker #(
    parameter int HALF_DIV = 8
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Watched outputs.
    input wire logic sclk_o,
    input wire logic sclk_oe_o,
    input wire logic sdo_o,
    input wire logic cs_pullup_o,
    input wire logic cs_sink_o,
    input wire logic ext_mode_o,
    input wire logic converting_o
);
    logic [7:0] low_cnt_q;
    logic [5:0] rise_cnt_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Length of the current low stretch of the serial clock, saturating.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) low_cnt_q <= 8'h00;
        else if (sclk_o) low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
    end
    // Rising edges since the last conversion; cleared while converting.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) rise_cnt_q <= 6'h00;
        else if (converting_o) rise_cnt_q <= 6'h00;
        else if ($rose(sclk_o)) rise_cnt_q <= rise_cnt_q + 6'h01;
    end
    sequence conv_end; $fell(converting_o) && !ext_mode_o; endsequence
    sequence sleep_out; !sclk_o && !sdo_o; endsequence
    sequence frame_end; $rose(converting_o) && rise_cnt_q != 6'h00; endsequence
    idle_high_a: assert property ($past(converting_o) && converting_o |-> sclk_o && sdo_o)
        else $error("clock or data low during conversion");
    done_low_a: assert property (conv_end |-> ##[0:1] sleep_out)
        else $error("pins not low at conversion end");
    sleep_min_a: assert property ($rose(sclk_o) |-> low_cnt_q >= HALF_DIV)
        else $error("low stretch shorter than half period");
    low_exact_a: assert property ($rose(sclk_o) && rise_cnt_q != 6'h00 |-> low_cnt_q == HALF_DIV)
        else $error("low phase length wrong");
    eoc_bit_a: assert property ($rose(sclk_o) && rise_cnt_q == 6'h00 |-> !sdo_o)
        else $error("first bit not zero");
    frame_len_a: assert property (frame_end |-> rise_cnt_q == 6'd24 && sdo_o && sclk_o)
        else $error("frame not 24 edges or end levels wrong");
    data_on_fall_a: assert property ($changed(sdo_o) && !converting_o && !$past(converting_o)
        && !ext_mode_o |-> $fell(sclk_o))
        else $error("data moved off a falling edge");
    cs_hold_a: assert property ($past(converting_o) && converting_o |-> cs_pullup_o && !cs_sink_o)
        else $error("chip select not held during conversion");
    sink_sleep_a: assert property (cs_sink_o |-> !converting_o && !cs_pullup_o)
        else $error("sink active outside sleep");
    ext_float_a: assert property (ext_mode_o |-> !sclk_oe_o)
        else $error("clock driven in external mode");
endmodule // adc_serial_out_checker

bind adc_serial_out adc_serial_out_checker #(.HALF_DIV(HALF_DIV)) adc_serial_out_checker_i (
    .clock_i(clock_i), .rst_i(rst_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o),
    .cs_pullup_o(cs_pullup_o), .cs_sink_o(cs_sink_o), .ext_mode_o(ext_mode_o),
    .converting_o(converting_o));
`default_nettype wire

// [adc_result_receiver.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Controller capturing results, plus the timing capacitor on chip select.
module adc_result_receiver #(
    parameter int DISCH = 10
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Pins.
    input wire logic sclk_i,
    input wire logic sclk_oe_i,
    input wire logic sdo_i,
    input wire logic cs_pullup_i,
    input wire logic cs_sink_i,
    input wire logic autostart_i,
    output logic cs_n_o
);
    logic [23:0] words[$];
    logic [23:0] shift_q;
    int nbits;
    int disch_q;
    // Capture on rising edges only while the device drives the clock.
    always @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) nbits = 0;
        else if (sclk_oe_i) begin
            shift_q = {shift_q[22:0], sdo_i};
            nbits++;
            if (nbits == 24) begin
                words.push_back(shift_q);
                nbits = 0;
            end
        end
    end
    // Capacitor: charged by the pull-up, discharged slowly by the sink.
    always @(posedge clock_i) begin
        if (rst_i || cs_pullup_i) disch_q <= 0;
        else if (cs_sink_i) disch_q <= disch_q + 1;
    end
    // Continuous mode ties the pin low; it never pulls the clock low.
    assign cs_n_o = autostart_i ? (disch_q < DISCH) : 1'b0;
endmodule // adc_result_receiver
`default_nettype wire

// [adc_serial_out_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Bench: continuous, autostart and external-mode runs.
module adc_serial_out_tb;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic result_valid_i = 1'b0;
    logic [23:0] result_data_i = 24'h000000;
    logic ext_low = 1'b0;
    logic autostart = 1'b0;
    logic notch = 1'b0;
    logic notch_o;
    logic result_ready_o, sclk_o, sclk_oe_o, sclk_pullup_o, sdo_o, cs_pullup_o, cs_sink_o;
    logic ext_mode_o, converting_o, cs_n;
    wire logic sclk_pin;
    int n_fail = 0;
    int checked = 0;
    logic [23:0] sent[$];
    // A pin that nobody drives or pulls is taken low by its load.
    assign sclk_pin = sclk_oe_o ? sclk_o : (ext_low ? 1'b0 : sclk_pullup_o);
    // Clock of 8 ns.
    always #4 clock_i = ~clock_i;
    adc_serial_out #(.HALF_DIV(4), .SLEEP_CYCLES(20), .CONV_CYCLES(30), .POR_CYCLES(20)
        ) adc_serial_out_i (
        .clock_i(clock_i), .rst_i(rst_i), .result_valid_i(result_valid_i),
        .result_ready_o(result_ready_o), .result_data_i(result_data_i), .sclk_i(sclk_pin),
        .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sclk_pullup_o(sclk_pullup_o), .sdo_o(sdo_o),
        .cs_n_i(cs_n), .cs_pullup_o(cs_pullup_o), .cs_sink_o(cs_sink_o),
        .ext_mode_o(ext_mode_o), .converting_o(converting_o),
        .notch_frequency_select_i(notch), .notch_frequency_select_o(notch_o));
    adc_result_receiver partner_i (
        .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_pin), .sclk_oe_i(sclk_oe_o),
        .sdo_i(sdo_o), .cs_pullup_i(cs_pullup_o), .cs_sink_i(cs_sink_o),
        .autostart_i(autostart), .cs_n_o(cs_n));
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    // Reset for 8 cycles and look at the pin levels held meanwhile.
    task automatic do_reset();
        rst_i = 1'b1;
        sent.delete();
        repeat (8) @(negedge clock_i);
        partner_i.words.delete();
        chk_bit(sclk_pullup_o, 1'b1);
        chk_bit(sclk_oe_o, 1'b0);
        chk_bit(sdo_o, 1'b1);
        rst_i = 1'b0;
    endtask
    // Offer up to max words back to back; stops at the first refusal.
    task automatic fill(input int max, output int n);
        n = 0;
        for (int i = 0; i < max && n == i; i++) begin
            @(negedge clock_i);
            result_data_i = 24'hC3A5F0 ^ (24'(i) << 7);
            result_valid_i = 1'b1;
            if (result_ready_o === 1'b1) begin
                sent.push_back(result_data_i);
                n++;
            end
        end
        @(negedge clock_i);
        result_valid_i = 1'b0;
    endtask
    // Wait for every word to arrive, then compare in order.
    task automatic check_frames();
        for (int k = 0; k < 500 * sent.size() && partner_i.words.size() < sent.size(); k++)
            @(negedge clock_i);
        chk_bit(partner_i.words.size() == sent.size(), 1'b1);
        for (int k = 0; k < sent.size() && k < partner_i.words.size(); k++)
            chk_word(partner_i.words[k], {1'b0, sent[k][23:1]});
    endtask
    task automatic t_continuous();
        int n;
        autostart = 1'b0;
        do_reset();
        fill(20, n);
        chk_bit(n == 16, 1'b1);
        check_frames();
        $display("test continuous done");
    endtask
    task automatic t_autostart();
        int n;
        autostart = 1'b1;
        do_reset();
        fill(3, n);
        check_frames();
        $display("test autostart done");
    endtask
    // Clock pin held low through power-on reset selects external mode.
    task automatic t_external();
        autostart = 1'b0;
        ext_low = 1'b1;
        do_reset();
        repeat (40) @(negedge clock_i);
        ext_low = 1'b0;
        chk_bit(ext_mode_o, 1'b1);
        repeat (20) @(negedge clock_i);
        chk_bit(sclk_oe_o, 1'b0);
        chk_bit(partner_i.words.size() == 0, 1'b1);
        // The rate select pin passes through its synchroniser to the core.
        chk_bit(notch_o, 1'b0);
        notch = 1'b1;
        repeat (8) @(negedge clock_i);
        chk_bit(notch_o, 1'b1);
        $display("test external done");
    endtask
    task automatic summarize();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence.
    initial begin
        t_continuous();
        t_autostart();
        t_external();
        summarize();
    end
    // Watchdog, over five times the expected run.
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule // adc_serial_out_tb
`default_nettype wire
